// [hw/gain_settle.sv]
/*
 Gain settle tracker for one headphone driver: restarts on each change and
 reports applied once the settle count has run out.
 Assumes restart is a one-cycle pulse on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module gain_settle
	import output_routing_pkg::*;
#(
	parameter int SETTLE = SETTLE_CYC
) (
	input  wire logic sys_clk,  // control clock
	input  wire logic rst_n,    // async reset, active low
	input  wire logic restart,  // new gain or mute written
	output var  logic applied   // all programmed gains in effect
);
	typedef struct packed {
		logic [7:0] count;
		logic       done;
	} settle_t;

	settle_t stateReg;
	settle_t stateNext;

	always_comb begin
		stateNext = stateReg;
		if (restart) begin
			stateNext.count = 8'(SETTLE);
			stateNext.done  = 1'b0;
		end else if (stateReg.count != 8'h00) begin
			stateNext.count = stateReg.count - 8'h01;
			stateNext.done  = (stateReg.count == 8'h01);
		end
	end

	// after reset the defaults count as applied only once the first settle ends
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateReg <= '{count: 8'(SETTLE), done: 1'b0};
		end else begin
			stateReg <= stateNext;
		end
	end

	assign applied = stateReg.done;
endmodule
`default_nettype wire

// [hw/output_routing_volume_regs.sv]
/*
 Output routing and volume register bank: stores the routing, volume and
 headphone driver registers, decodes them into control levels for the analog
 path, and reports the per-driver gain-applied status.
 Assumes the register port is synchronous to sys_clk; wrEn and rdEn are
 one-cycle strobes with an 8-bit byte address.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RULE_01] Left converter field: 00 none, 01 left mixer, 10 left headphone direct.
// [RULE_02] Analog input one bit set connects it to the left mixer.
// [RULE_03] Analog input two left bit set connects it to the left mixer.
// [RULE_04] Right converter field: 00 none, 01 right mixer, 10 right headphone direct.
// [RULE_05] Analog input two right bit set connects it to the right mixer.
// [RULE_06] Differential bit feeds left headphone output into right headphone input.
// [RULE_07] Left headphone volume top bit connects left volume stage to driver.
// [RULE_08] Left headphone seven-bit attenuation code, reset all ones.
// [RULE_09] Right headphone volume top bit connects right volume stage to driver.
// [RULE_10] Right headphone seven-bit attenuation code, reset all ones.
// [RULE_11] Speaker volume top bit connects left volume stage to speaker driver.
// [RULE_12] Speaker seven-bit attenuation code, reset all ones.
// [RULE_13] Left headphone gain 0 to 9 dB; codes above nine never written.
// [RULE_14] Left headphone muted while its mute bit is 0; resets to 0.
// [RULE_15] Left headphone status reads 1 once all programmed gains applied.
// [RULE_16] Right headphone gain 0 to 9 dB; codes above nine never written.
// [RULE_17] Right headphone muted while its mute bit is 0; resets to 0.
// [RULE_18] Right headphone status reads 1 once all programmed gains applied.
// [RULE_19] Software keeps right driver reserved bit 1 at one.
// [RULE_20] Software writes zero into the top bit of each driver register.
// [RULE_21] Status drops on a gain or mute write and rises when done; the code drops it only when the write changes the gain or mute bits.
// [RULE_22] Reserved routing code 11 makes no connection.
module output_routing_volume_regs
	import output_routing_pkg::*;
(
	input  wire logic        sys_clk,  // control clock, 10 MHz
	input  wire logic        rst_n,    // async reset, active low
	input  wire logic        wrEn,     // write strobe
	input  wire logic        rdEn,     // read strobe
	input  wire logic [7:0]  addr,     // register address
	input  wire logic [7:0]  wrData,   // write data
	output var  logic [7:0]  rdData,   // read data, valid cycle after rdEn
	output var  route_ctrl_t ctrl      // decoded controls for the analog path
);
	typedef struct packed {
		logic [7:0]  routing;
		logic [7:0]  lhpVol;
		logic [7:0]  rhpVol;
		logic [7:0]  spkVol;
		logic [7:0]  lhpDrv;
		logic [7:0]  rhpDrv;
		logic [7:0]  rdData;
		route_ctrl_t ctrl;
	} bank_t;

	bank_t stateReg;
	bank_t stateNext;
	logic  lhpRestart;
	logic  rhpRestart;
	logic  lhpApplied;
	logic  rhpApplied;

	// reserved code 11 decodes to neither path
	function automatic dac_route_t decodeRoute(input logic [1:0] code);
		dac_route_t r;
		r.toMixer  = (code == ROUTE_MIXER);
		r.toDirect = (code == ROUTE_DIRECT);
		return r;
	endfunction

	function automatic logic [7:0] drvWriteVal(input logic [7:0] d);
		// status bit is read-only, kept out of storage
		return {d[7:1], 1'b0};
	endfunction

	// restart only on a real change of gain or mute
	assign lhpRestart = wrEn && (addr == OFS_LHP_DRV) &&
		(wrData[6:2] != stateReg.lhpDrv[6:2]); // RULE_21
	assign rhpRestart = wrEn && (addr == OFS_RHP_DRV) &&
		(wrData[6:2] != stateReg.rhpDrv[6:2]); // RULE_21

	gain_settle #(
		.SETTLE (SETTLE_CYC)
	) lhpSettle (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.restart (lhpRestart),
		.applied (lhpApplied)
	);

	gain_settle #(
		.SETTLE (SETTLE_CYC)
	) rhpSettle (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.restart (rhpRestart),
		.applied (rhpApplied)
	);

	always_comb begin
		stateNext = stateReg;
		if (wrEn) begin
			case (addr)
				OFS_ROUTING: begin
					stateNext.routing = wrData;
				end
				OFS_LHP_VOL: begin
					stateNext.lhpVol = wrData;
				end
				OFS_RHP_VOL: begin
					stateNext.rhpVol = wrData;
				end
				OFS_SPK_VOL: begin
					stateNext.spkVol = wrData;
				end
				OFS_LHP_DRV: begin
					stateNext.lhpDrv = drvWriteVal(wrData); // RULE_13
				end
				OFS_RHP_DRV: begin
					// reserved bits stored as written; software keeps them legal
					stateNext.rhpDrv = drvWriteVal(wrData); // RULE_16
				end
				default: begin
				end
			endcase
		end
		if (rdEn) begin
			case (addr)
				OFS_ROUTING: stateNext.rdData = stateReg.routing;
				OFS_LHP_VOL: stateNext.rdData = stateReg.lhpVol;
				OFS_RHP_VOL: stateNext.rdData = stateReg.rhpVol;
				OFS_SPK_VOL: stateNext.rdData = stateReg.spkVol;
				OFS_RSVD_A:  stateNext.rdData = RST_RSVD_A;
				OFS_LHP_DRV: stateNext.rdData = {stateReg.lhpDrv[7:1], lhpApplied}; // RULE_15
				OFS_RHP_DRV: stateNext.rdData = {stateReg.rhpDrv[7:1], rhpApplied}; // RULE_18
				default:     stateNext.rdData = 8'h00;
			endcase
		end
		// decode from the new contents so outputs follow a write by one cycle
		stateNext.ctrl.dacL        = decodeRoute(stateNext.routing[POS_DACL +: 2]); // RULE_01 RULE_22
		stateNext.ctrl.dacR        = decodeRoute(stateNext.routing[POS_DACR +: 2]); // RULE_04 RULE_22
		stateNext.ctrl.ain1ToLeft  = stateNext.routing[POS_AIN1L]; // RULE_02
		stateNext.ctrl.ain2ToLeft  = stateNext.routing[POS_AIN2L]; // RULE_03
		stateNext.ctrl.ain2ToRight = stateNext.routing[POS_AIN2R]; // RULE_05
		stateNext.ctrl.diffFeed    = stateNext.routing[POS_DIFF]; // RULE_06
		stateNext.ctrl.volToLhp    = stateNext.lhpVol[POS_ROUTE]; // RULE_07
		stateNext.ctrl.lhpAtten    = stateNext.lhpVol[6:0]; // RULE_08
		stateNext.ctrl.volToRhp    = stateNext.rhpVol[POS_ROUTE]; // RULE_09
		stateNext.ctrl.rhpAtten    = stateNext.rhpVol[6:0]; // RULE_10
		stateNext.ctrl.volToSpk    = stateNext.spkVol[POS_ROUTE]; // RULE_11
		stateNext.ctrl.spkAtten    = stateNext.spkVol[6:0]; // RULE_12
		stateNext.ctrl.lhpGain     = stateNext.lhpDrv[POS_GAIN +: 4]; // RULE_13
		stateNext.ctrl.rhpGain     = stateNext.rhpDrv[POS_GAIN +: 4]; // RULE_16
		stateNext.ctrl.lhpUnmute   = stateNext.lhpDrv[POS_UNMUTE]; // RULE_14
		stateNext.ctrl.rhpUnmute   = stateNext.rhpDrv[POS_UNMUTE]; // RULE_17
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateReg.routing <= RST_ROUTING;
			stateReg.lhpVol  <= RST_VOL;
			stateReg.rhpVol  <= RST_VOL;
			stateReg.spkVol  <= RST_VOL;
			stateReg.lhpDrv  <= RST_DRV;
			stateReg.rhpDrv  <= RST_DRV; // RULE_19
			stateReg.rdData  <= 8'h00;
			stateReg.ctrl    <= '{dacL: '{1'b0, 1'b0}, dacR: '{1'b0, 1'b0},
				lhpAtten: 7'h7F, rhpAtten: 7'h7F, spkAtten: 7'h7F, default: '0};
		end else begin
			stateReg <= stateNext;
		end
	end

	assign rdData = stateReg.rdData;
	assign ctrl   = stateReg.ctrl;

	AST_DACL_RESERVED: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_22
		(stateReg.routing[7:6] == 2'h3) |-> !(ctrl.dacL.toMixer || ctrl.dacL.toDirect))
		else $error("reserved left route code made a connection");
	AST_DACL_DECODE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_01
		ctrl.dacL.toDirect == (stateReg.routing[7:6] == 2'h2))
		else $error("left direct route mismatch");
	AST_DACR_DECODE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_04
		ctrl.dacR.toMixer == (stateReg.routing[3:2] == 2'h1))
		else $error("right mixer route mismatch");
	AST_ROUTE_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_06
		(wrEn && addr == OFS_ROUTING) |=> (ctrl.diffFeed == $past(wrData[0]) &&
		ctrl.ain1ToLeft == $past(wrData[5])))
		else $error("routing write not reflected");
	AST_LHP_VOL: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_08
		(wrEn && addr == OFS_LHP_VOL) |=> (ctrl.lhpAtten == $past(wrData[6:0]) &&
		ctrl.volToLhp == $past(wrData[7])))
		else $error("left headphone volume not updated");
	AST_SPK_VOL: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_11
		(wrEn && addr == OFS_SPK_VOL) |=> ctrl.volToSpk == $past(wrData[7]))
		else $error("speaker route not updated");
	AST_LHP_MUTE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_14
		(wrEn && addr == OFS_LHP_DRV) |=> ctrl.lhpUnmute == $past(wrData[2]))
		else $error("left mute not updated");
	AST_LHP_DROP: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_21
		lhpRestart |=> !lhpApplied [*8])
		else $error("left status did not drop after change");
	// ten quiet cycles, split so no repetition grows long
	AST_LHP_RISE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_15
		(lhpRestart ##1 !lhpRestart [*5] ##1 !lhpRestart [*5]) |=> lhpApplied)
		else $error("left status did not rise after settle");
	AST_RHP_RISE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_18
		(rhpRestart ##1 !rhpRestart [*5] ##1 !rhpRestart [*5]) |=> rhpApplied)
		else $error("right status did not rise after settle");

	// routing decode against the stored field and the written data
	AST_DACL_MIXER: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_01
		ctrl.dacL.toMixer ==
		(stateReg.routing[7:6] == 2'h1))
		else $error("left mixer route mismatch");

	AST_DACR_DIRECT: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_04
		ctrl.dacR.toDirect ==
		(stateReg.routing[3:2] == 2'h2))
		else $error("right direct route mismatch");

	AST_DACR_RESERVED: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_22
		(stateReg.routing[3:2] == 2'h3) |->
		!(ctrl.dacR.toMixer || ctrl.dacR.toDirect))
		else $error("reserved right route code made a connection");

	AST_ANALOG_INPUT_ONE_LEFT: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_02
		(wrEn && addr == OFS_ROUTING) |=>
		ctrl.ain1ToLeft == $past(wrData[5]))
		else $error("input one left route not updated");

	AST_ANALOG_INPUT_TWO_LEFT: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_03
		(wrEn && addr == OFS_ROUTING) |=>
		ctrl.ain2ToLeft == $past(wrData[4]))
		else $error("input two left route not updated");

	AST_ANALOG_INPUT_TWO_RIGHT: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_05
		(wrEn && addr == OFS_ROUTING) |=>
		ctrl.ain2ToRight == $past(wrData[1]))
		else $error("input two right route not updated");

	AST_ROUTE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_01
		!(wrEn && addr == OFS_ROUTING) |=>
		($stable(ctrl.dacL) && $stable(ctrl.dacR) && $stable(ctrl.diffFeed)))
		else $error("routing changed without a write");

	// volume stages
	AST_RHP_VOL: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_09
		(wrEn && addr == OFS_RHP_VOL) |=>
		(ctrl.volToRhp == $past(wrData[7]) && ctrl.rhpAtten == $past(wrData[6:0])))
		else $error("right headphone volume not updated");

	AST_SPK_ATTEN: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_12
		(wrEn && addr == OFS_SPK_VOL) |=>
		ctrl.spkAtten == $past(wrData[6:0]))
		else $error("speaker attenuation not updated");

	AST_LHP_VOL_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_08
		!(wrEn && addr == OFS_LHP_VOL) |=>
		($stable(ctrl.lhpAtten) && $stable(ctrl.volToLhp)))
		else $error("left headphone volume changed without a write");

	AST_RHP_VOL_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_10
		!(wrEn && addr == OFS_RHP_VOL) |=>
		($stable(ctrl.rhpAtten) && $stable(ctrl.volToRhp)))
		else $error("right headphone volume changed without a write");

	AST_SPK_VOL_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_12
		!(wrEn && addr == OFS_SPK_VOL) |=>
		($stable(ctrl.spkAtten) && $stable(ctrl.volToSpk)))
		else $error("speaker volume changed without a write");

	// headphone driver gain and mute
	AST_LHP_GAIN: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_13
		(wrEn && addr == OFS_LHP_DRV) |=>
		ctrl.lhpGain == $past(wrData[6:3]))
		else $error("left gain not updated");

	AST_RHP_GAIN: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_16
		(wrEn && addr == OFS_RHP_DRV) |=>
		ctrl.rhpGain == $past(wrData[6:3]))
		else $error("right gain not updated");

	// codes above nine are stored as written, so only legal software keeps this
	AST_LHP_GAIN_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_13
		ctrl.lhpGain <= GAIN_MAX)
		else $error("left gain outside legal range");

	AST_RHP_GAIN_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_16
		ctrl.rhpGain <= GAIN_MAX)
		else $error("right gain outside legal range");

	AST_RHP_MUTE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_17
		(wrEn && addr == OFS_RHP_DRV) |=>
		ctrl.rhpUnmute == $past(wrData[2]))
		else $error("right mute not updated");

	AST_LHP_MUTE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_14
		!(wrEn && addr == OFS_LHP_DRV) |=>
		($stable(ctrl.lhpUnmute) && $stable(ctrl.lhpGain)))
		else $error("left driver changed without a write");

	AST_RHP_MUTE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_17
		!(wrEn && addr == OFS_RHP_DRV) |=>
		($stable(ctrl.rhpUnmute) && $stable(ctrl.rhpGain)))
		else $error("right driver changed without a write");

	AST_RHP_KEEP_ONE: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_19
		stateReg.rhpDrv[1])
		else $error("right driver reserved bit cleared");

	AST_DRV_TOP_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_20
		!(stateReg.lhpDrv[7] || stateReg.rhpDrv[7]))
		else $error("driver reserved top bit set");

	// gain-applied status
	AST_RHP_DROP: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_21
		rhpRestart |=>
		!rhpApplied [*8])
		else $error("right status did not drop after change");

	AST_LHP_APPLIED_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_15
		(lhpApplied && !lhpRestart) |=>
		lhpApplied)
		else $error("left status fell without a change");

	AST_RHP_APPLIED_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_18
		(rhpApplied && !rhpRestart) |=>
		rhpApplied)
		else $error("right status fell without a change");

	AST_LHP_READ: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_15
		(rdEn && addr == OFS_LHP_DRV) |=>
		rdData[0] == $past(lhpApplied))
		else $error("left status not read back");

	AST_RHP_READ: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_18
		(rdEn && addr == OFS_RHP_DRV) |=>
		rdData[0] == $past(rhpApplied))
		else $error("right status not read back");

	// read data must stand until the next read strobe
	AST_RDATA_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_15
		!rdEn |=>
		$stable(rdData))
		else $error("read data changed without a read");

	COV_DIFF: cover property (@(posedge sys_clk) disable iff (!rst_n) ctrl.diffFeed && ctrl.dacL.toDirect);
	COV_LHP_SETTLE: cover property (@(posedge sys_clk) disable iff (!rst_n) lhpRestart ##[1:20] lhpApplied);
	COV_RHP_UNMUTE: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(ctrl.rhpUnmute));
	COV_DACR_DIRECT: cover property (@(posedge sys_clk) disable iff (!rst_n) ctrl.dacR.toDirect);
	COV_RSVD_ROUTE: cover property (@(posedge sys_clk) disable iff (!rst_n)
		(stateReg.routing[7:6] == 2'h3) && (stateReg.routing[3:2] == 2'h3));
endmodule
`default_nettype wire

// [inc/output_routing_pkg.sv]
/*
 Package for the output routing and volume register bank: offsets, field
 positions, reset values, routing codes and the gain settle timing.
 Assumes an 8-bit register port with a byte address, synchronous to sys_clk.
*/
package output_routing_pkg;
	localparam logic [7:0] OFS_ROUTING   = 8'h23;
	localparam logic [7:0] OFS_LHP_VOL   = 8'h24;
	localparam logic [7:0] OFS_RHP_VOL   = 8'h25;
	localparam logic [7:0] OFS_SPK_VOL   = 8'h26;
	localparam logic [7:0] OFS_RSVD_A    = 8'h27;
	localparam logic [7:0] OFS_LHP_DRV   = 8'h28;
	localparam logic [7:0] OFS_RHP_DRV   = 8'h29;

	localparam logic [7:0] RST_ROUTING   = 8'h00;
	localparam logic [7:0] RST_VOL       = 8'h7F;
	localparam logic [7:0] RST_RSVD_A    = 8'h7F;
	localparam logic [7:0] RST_DRV       = 8'h02;

	localparam int POS_DACL   = 6;
	localparam int POS_AIN1L  = 5;
	localparam int POS_AIN2L  = 4;
	localparam int POS_DACR   = 2;
	localparam int POS_AIN2R  = 1;
	localparam int POS_DIFF   = 0;
	localparam int POS_ROUTE  = 7;
	localparam int POS_GAIN   = 3;
	localparam int POS_UNMUTE = 2;
	localparam int POS_APPLY  = 0;

	localparam logic [1:0] ROUTE_NONE   = 2'h0;
	localparam logic [1:0] ROUTE_MIXER  = 2'h1;
	localparam logic [1:0] ROUTE_DIRECT = 2'h2;

	localparam logic [3:0] GAIN_MAX = 4'h9;

	// time for a new gain or mute setting to take effect in the driver
	localparam int SETTLE_NS     = 1000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic       toMixer;
		logic       toDirect;
	} dac_route_t;

	typedef struct packed {
		dac_route_t dacL;
		dac_route_t dacR;
		logic       ain1ToLeft;
		logic       ain2ToLeft;
		logic       ain2ToRight;
		logic       diffFeed;
		logic       volToLhp;
		logic       volToRhp;
		logic       volToSpk;
		logic [6:0] lhpAtten;
		logic [6:0] rhpAtten;
		logic [6:0] spkAtten;
		logic [3:0] lhpGain;
		logic [3:0] rhpGain;
		logic       lhpUnmute;
		logic       rhpUnmute;
	} route_ctrl_t;
endpackage

// [verif/output_routing_volume_regs_bench.sv]
/*
 Self-checking bench for the output routing and volume register bank:
 reset values, routing decode, volume stages, headphone driver controls.
 Assumes the design package is compiled first; chk compares reads and controls here, assertions live in the design.
*/
`timescale 1ns/1ps
`default_nettype none
module output_routing_volume_regs_bench
	import output_routing_pkg::*;
;
	logic        sysClk;
	logic        rstN;
	logic        wrEn;
	logic        rdEn;
	logic [7:0]  addr;
	logic [7:0]  wrData;
	logic [7:0]  rdData;
	route_ctrl_t ctrl;
	int          nFail;
	int          testsRun;

	output_routing_volume_regs u_output_routing_volume_regs (
		.sys_clk (sysClk),
		.rst_n   (rstN),
		.wrEn    (wrEn),
		.rdEn    (rdEn),
		.addr    (addr),
		.wrData  (wrData),
		.rdData  (rdData),
		.ctrl    (ctrl)
	);

	initial begin
		sysClk = 1'b0;
		forever #50 sysClk = ~sysClk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		testsRun++;
		if (got !== exp) begin
			nFail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sysClk);
		#1;
		wrEn = 1'b1;
		addr = a;
		wrData = d;
		@(posedge sysClk);
		#1;
		wrEn = 1'b0;
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sysClk);
		#1;
		rdEn = 1'b1;
		addr = a;
		@(posedge sysClk);
		#1;
		rdEn = 1'b0;
		chk(rdData, exp);
	endtask

	task automatic resetScan();
		// status must still be pending this soon after release
		rdChk(OFS_LHP_DRV, 8'h02);
		rdChk(OFS_RHP_DRV, 8'h02);
		rdChk(OFS_ROUTING, 8'h00);
		rdChk(OFS_LHP_VOL, 8'h7F);
		rdChk(OFS_RHP_VOL, 8'h7F);
		rdChk(OFS_SPK_VOL, 8'h7F);
		rdChk(OFS_RSVD_A, 8'h7F);
		chk({1'b0, ctrl.spkAtten}, 8'h7F);
		chk({6'h00, ctrl.lhpUnmute, ctrl.rhpUnmute}, 8'h00);
		repeat (12) @(posedge sysClk);
		rdChk(OFS_LHP_DRV, 8'h03);
	endtask

	task automatic routeScan();
		logic [7:0] pat [4];
		logic [1:0] e;
		pat = '{8'h20, 8'h10, 8'h02, 8'h01};
		for (int c = 0; c < 4; c++) begin
			wr(OFS_ROUTING, {c[1:0], 2'b00, c[1:0], 2'b00});
			// reserved code must open no path at all
			e = (c == 1) ? 2'b10 : ((c == 2) ? 2'b01 : 2'b00);
			chk({6'h00, ctrl.dacL}, {6'h00, e});
			chk({6'h00, ctrl.dacR}, {6'h00, e});
		end
		for (int i = 0; i < 4; i++) begin
			wr(OFS_ROUTING, pat[i]);
			chk({4'h0, ctrl.ain1ToLeft, ctrl.ain2ToLeft, ctrl.ain2ToRight, ctrl.diffFeed}, 8'h08 >> i);
		end
		rdChk(OFS_ROUTING, 8'h01);
	endtask

	task automatic volScan();
		wr(OFS_LHP_VOL, 8'h95);
		wr(OFS_RHP_VOL, 8'h16);
		wr(OFS_SPK_VOL, 8'h80);
		wr(OFS_RSVD_A, 8'h00);
		chk({ctrl.volToLhp, ctrl.lhpAtten}, 8'h95);
		chk({ctrl.volToRhp, ctrl.rhpAtten}, 8'h16);
		chk({ctrl.volToSpk, ctrl.spkAtten}, 8'h80);
		rdChk(OFS_LHP_VOL, 8'h95);
		rdChk(OFS_RHP_VOL, 8'h16);
		rdChk(OFS_SPK_VOL, 8'h80);
		rdChk(OFS_RSVD_A, 8'h7F);
		rdChk(8'h30, 8'h00);
	endtask

	task automatic leftDrv();
		wr(OFS_LHP_DRV, 8'h4C);
		chk({3'h0, ctrl.lhpGain, ctrl.lhpUnmute}, 8'h13);
		rdChk(OFS_LHP_DRV, 8'h4C);
		repeat (10) @(posedge sysClk);
		rdChk(OFS_LHP_DRV, 8'h4D);
		wr(OFS_LHP_DRV, 8'h48);
		chk({7'h00, ctrl.lhpUnmute}, 8'h00);
		rdChk(OFS_LHP_DRV, 8'h48);
	endtask

	task automatic rightDrv();
		// reserved bit 1 kept at one on every write
		wr(OFS_RHP_DRV, 8'h06);
		chk({3'h0, ctrl.rhpGain, ctrl.rhpUnmute}, 8'h01);
		rdChk(OFS_RHP_DRV, 8'h06);
		repeat (10) @(posedge sysClk);
		rdChk(OFS_RHP_DRV, 8'h07);
		wr(OFS_RHP_DRV, 8'h4A);
		chk({3'h0, ctrl.rhpGain, ctrl.rhpUnmute}, 8'h12);
		rdChk(OFS_RHP_DRV, 8'h4A);
	endtask

	task automatic conclude();
		$display("checks %0d, mismatches %0d", testsRun, nFail);
		if (nFail == 0 && testsRun > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge sysClk);
		nFail++;
		conclude();
	end

	initial begin
		nFail = 0;
		testsRun = 0;
		rstN = 1'b0;
		wrEn = 1'b0;
		rdEn = 1'b0;
		addr = 8'h00;
		wrData = 8'h00;
		repeat (5) @(posedge sysClk);
		#1;
		rstN = 1'b1;
		resetScan();
		routeScan();
		volScan();
		leftDrv();
		rightDrv();
		conclude();
	end
endmodule
`default_nettype wire
